/* File: verilog/pll_cfg_pkg.sv */
// Package with register map, field positions and carriers for the PLL configuration block.
//
// Contract
// [RQ1] A rising phase-advance bit (bit 15) steps that PLL's VCO output one eighth cycle earlier.
// [RQ2] A phase step is applied whatever the PLL's S divider value is.
// [RQ3] Phase stepping is edge triggered: one step per 0-to-1 change, none while the bit stays 1.
// [RQ4] A rising retard bit (bit 11) steps the VCO output one eighth cycle later, edge triggered.
// [RQ5] Software writes the feedback restart bit (bit 14) after changing order, S or divide value.
// [RQ6] Software writes the output restart bit (bit 13) after changing a PLL1 output divider.
// [RQ7] A 1 in the resync bit (bit 12) runs a reset cycle that sends sync pulses to its outputs.
// [RQ8] Second setup register: ratio flag at bit 10, modulus bits 15:6 in bits 9:0.
// [RQ9] PLL2 first setup register (0x8): 36-bit divide value in bits 39:4, bits 3:0 reserved.
// [RQ10] PLL2 second word mirrors PLL1: N 39:37, scale 36:32, order 31:29, band 28:24, S 22:21.
// [RQ11] Software sets the oscillator trim bit (bit 15) to 1 for a crystal below 33 MHz, else 0.
// [RQ12] The load code in bits 14:12 selects (10 + 2 x code) pF, from 10 pF to 24 pF.
// [RQ13] Rising control bits are found against their last registered value as one-cycle pulses.
package pll_cfg_pkg;
   // ==========================================================
   // Register map
   localparam logic [3:0] PLL1_CONTROL_SECOND_IDX = 4'h7;
   localparam logic [3:0] PLL2_DIVIDER_FIRST_IDX = 4'h8;
   localparam logic [3:0] PLL2_CONTROL_SECOND_IDX = 4'h9;
   localparam logic [3:0] CRYSTAL_TWO_SETUP_IDX = 4'hA;
   localparam int REG_W = 40;
   localparam logic [39:0] PLL1_CONTROL_SECOND_RST = 40'h00_0000_0000;
   localparam logic [39:0] PLL2_DIVIDER_FIRST_RST = 40'h00_0000_000E;
   localparam logic [39:0] PLL2_CONTROL_SECOND_RST = 40'h00_0000_0000;
   localparam logic [15:0] CRYSTAL_TWO_SETUP_RST = 16'h0000;
   // ==========================================================
   // Field positions of the second configuration register
   localparam int FWD_BIT = 15;
   localparam int FB_RESTART_BIT = 14;
   localparam int OUT_RESTART_BIT = 13;
   localparam int RESYNC_BIT = 12;
   localparam int BACK_BIT = 11;
   localparam int RATIO_BIT = 10;
   localparam int S_LSB = 21;
   // ==========================================================
   // Oscillator setup fields and load model
   localparam int TRIM_BIT = 15;
   localparam int LOAD_LSB = 12;
   localparam int GAIN_LSB = 9;
   localparam int LOAD_BASE_PF = 10;
   localparam int LOAD_STEP_PF = 2;
   // Length of the resync cycle in clock cycles.
   localparam int RESYNC_CYCLES = 8;

   typedef struct packed {
      logic [2:0] n_field;
      logic [4:0] d_scale;
      logic [2:0] modulator_order;
      logic [4:0] freq_band_sel;
      logic [1:0] s_divider;
      logic ratio_select;
      logic [9:0] mod_upper;
   } pll_setup_s;

   typedef struct packed {
      logic phase_fwd;
      logic phase_back;
      logic feedback_restart;
      logic out_restart;
      logic resync_sync;
      logic resync_busy;
   } pll_pulse_s;
endpackage

/* File: verilog/pll_step_ctrl.sv */
// One PLL's edge detector, eighth-cycle phase tracker and resync sequencer.
`timescale 1ns/10ps
module pll_step_ctrl
   import pll_cfg_pkg::*;
(
   input wire logic core_clk_in, // Clock.
   input wire logic reset_in, // Synchronous reset.
   input wire logic [15:10] ctrl_bits_in, // Stored control bits 15..10.
   output logic [2:0] phase_out, // Current eighth-cycle phase.
   output pll_pulse_s pulse_out // One-cycle requests and resync busy flag.
);
   typedef enum logic [1:0] {IDLE = 2'b01, RUN = 2'b10} seq_e;
   logic [15:11] prev_reg;
   logic [2:0] phase_reg;
   logic [3:0] cnt_reg;
   seq_e state_reg;
   wire logic [15:11] rise = ctrl_bits_in[15:11] & ~prev_reg; // RQ13
   wire logic fwd = rise[FWD_BIT]; // RQ3
   wire logic back = rise[BACK_BIT]; // RQ4
   wire logic start = rise[RESYNC_BIT] && state_reg == IDLE; // RQ7

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         prev_reg <= '0;
         phase_reg <= 3'h0;
         cnt_reg <= 4'h0;
         state_reg <= IDLE;
      end else begin
         prev_reg <= ctrl_bits_in[15:11]; // RQ13
         // Both edges together cancel; S divider plays no part. RQ2
         if (fwd && !back) begin
            phase_reg <= phase_reg + 3'h1; // RQ1
         end else if (back && !fwd) begin
            phase_reg <= phase_reg - 3'h1; // RQ4
         end
         unique case (state_reg)
            IDLE: begin
               if (start) begin
                  state_reg <= RUN;
                  cnt_reg <= 4'(RESYNC_CYCLES - 1);
               end
            end
            RUN: begin
               cnt_reg <= cnt_reg - 4'h1;
               if (cnt_reg == 4'h0) begin
                  state_reg <= IDLE;
               end
            end
         endcase
      end
   end

   assign phase_out = phase_reg;
   // One driver for the whole carrier; the sync pulse fires at the end of the resync cycle.
   assign pulse_out = '{
      phase_fwd: fwd,
      phase_back: back,
      feedback_restart: rise[FB_RESTART_BIT],
      out_restart: rise[OUT_RESTART_BIT],
      resync_sync: state_reg == RUN && cnt_reg == 4'h0, // RQ7
      resync_busy: state_reg == RUN
   };

   a_phase_fwd_step: assert property (@(posedge core_clk_in) disable iff (reset_in)
      fwd && !back |=> phase_reg == $past(phase_reg) + 3'h1) // RQ1
      else $error("phase did not advance by one eighth");
   a_phase_back_step: assert property (@(posedge core_clk_in) disable iff (reset_in)
      back && !fwd |=> phase_reg == $past(phase_reg) - 3'h1) // RQ4
      else $error("phase did not retard by one eighth");
   a_held_bit_idle: assert property (@(posedge core_clk_in) disable iff (reset_in)
      ctrl_bits_in[FWD_BIT] && $past(ctrl_bits_in[FWD_BIT]) |-> !fwd) // RQ3
      else $error("held advance bit stepped again");
   a_edge_one_cycle: assert property (@(posedge core_clk_in) disable iff (reset_in)
      pulse_out.feedback_restart |=> !pulse_out.feedback_restart) // RQ13
      else $error("restart pulse longer than one cycle");
   a_resync_sync: assert property (@(posedge core_clk_in) disable iff (reset_in)
      start |-> ##8 pulse_out.resync_sync) // RQ7
      else $error("resync cycle gave no sync pulse");
endmodule // pll_step_ctrl

/* File: verilog/pll_cfg_regs.sv */
// Register file and control outputs of the two-PLL configuration block.
`timescale 1ns/10ps
module pll_cfg_regs
   import pll_cfg_pkg::*;
(
   input wire logic core_clk_in, // Clock, 25 MHz.
   input wire logic reset_in, // Synchronous reset, active high.
   input wire logic [3:0] addr_in, // Register index.
   input wire logic [39:0] wdata_in, // Write data.
   input wire logic wr_in, // Write strobe.
   input wire logic rd_in, // Read strobe.
   output logic [39:0] rdata_out, // Read data, cycle after strobe.
   output pll_setup_s setup_p1_out, // PLL1 setup fields.
   output pll_setup_s setup_p2_out, // PLL2 setup fields.
   output logic [35:0] divide_value_p2_out, // PLL2 divide value.
   output logic [2:0] phase_p1_out, // PLL1 eighth-cycle phase.
   output logic [2:0] phase_p2_out, // PLL2 eighth-cycle phase.
   output pll_pulse_s pulse_p1_out, // PLL1 request pulses.
   output pll_pulse_s pulse_p2_out, // PLL2 request pulses.
   output logic osc_b_freq_trim_out, // Oscillator two trim.
   output logic [2:0] osc_b_load_code_out, // Oscillator two load code.
   output logic [5:0] osc_b_load_pf_out, // Selected load in pF.
   output logic [2:0] osc_b_drive_gain_out // Oscillator two drive gain.
);
   logic [39:0] pll1_control_second_reg;
   logic [39:0] pll2_divider_first_reg;
   logic [39:0] pll2_control_second_reg;
   logic [15:0] crystal_two_setup_reg;
   logic [39:0] rdata_reg;

   wire logic sel_p1c = addr_in == PLL1_CONTROL_SECOND_IDX;
   wire logic sel_p2d = addr_in == PLL2_DIVIDER_FIRST_IDX;
   wire logic sel_p2c = addr_in == PLL2_CONTROL_SECOND_IDX;
   wire logic sel_osc = addr_in == CRYSTAL_TWO_SETUP_IDX;
   // Reserved bits 3:0 of the divide register keep their default. RQ9
   wire logic [39:0] p2d_wr = {wdata_in[39:4], PLL2_DIVIDER_FIRST_RST[3:0]};
   // Unmapped indices read as zero.
   wire logic [39:0] rd_mux = sel_p1c ? pll1_control_second_reg :
                              sel_p2d ? pll2_divider_first_reg :
                              sel_p2c ? pll2_control_second_reg :
                              sel_osc ? {24'h000000, crystal_two_setup_reg} : 40'h00_0000_0000;

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         pll1_control_second_reg <= PLL1_CONTROL_SECOND_RST;
         pll2_divider_first_reg <= PLL2_DIVIDER_FIRST_RST;
         pll2_control_second_reg <= PLL2_CONTROL_SECOND_RST;
         crystal_two_setup_reg <= CRYSTAL_TWO_SETUP_RST;
         rdata_reg <= 40'h00_0000_0000;
      end else begin
         if (wr_in && sel_p1c) begin
            pll1_control_second_reg <= wdata_in; // RQ8
         end
         if (wr_in && sel_p2d) begin
            pll2_divider_first_reg <= p2d_wr; // RQ9
         end
         if (wr_in && sel_p2c) begin
            pll2_control_second_reg <= wdata_in; // RQ10
         end
         if (wr_in && sel_osc) begin
            crystal_two_setup_reg <= wdata_in[15:0]; // RQ11
         end
         rdata_reg <= rd_in ? rd_mux : 40'h00_0000_0000;
      end
   end

   function automatic pll_setup_s unpack_setup(input logic [39:0] r);
      pll_setup_s s;
      s.n_field = r[39:37];
      s.d_scale = r[36:32];
      s.modulator_order = r[31:29];
      s.freq_band_sel = r[28:24];
      s.s_divider = r[S_LSB +: 2];
      s.ratio_select = r[RATIO_BIT];
      s.mod_upper = r[9:0];
      return s;
   endfunction

   assign setup_p1_out = unpack_setup(pll1_control_second_reg); // RQ8
   assign setup_p2_out = unpack_setup(pll2_control_second_reg); // RQ10
   assign divide_value_p2_out = pll2_divider_first_reg[39:4]; // RQ9
   assign rdata_out = rdata_reg;
   assign osc_b_freq_trim_out = crystal_two_setup_reg[TRIM_BIT]; // RQ11
   assign osc_b_load_code_out = crystal_two_setup_reg[LOAD_LSB +: 3]; // RQ12
   assign osc_b_load_pf_out = 6'(LOAD_BASE_PF) +
                              6'(LOAD_STEP_PF) * {3'h0, osc_b_load_code_out}; // RQ12
   assign osc_b_drive_gain_out = crystal_two_setup_reg[GAIN_LSB +: 3];

   // Restart bits are stored bits whose rising edges give one-cycle request pulses; software follows setup changes with them. RQ5 RQ6
   pll_step_ctrl u_p1 (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .ctrl_bits_in(pll1_control_second_reg[15:10]),
      .phase_out(phase_p1_out),
      .pulse_out(pulse_p1_out)
   );
   pll_step_ctrl u_p2 (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .ctrl_bits_in(pll2_control_second_reg[15:10]),
      .phase_out(phase_p2_out),
      .pulse_out(pulse_p2_out)
   );

   a_read_one_cycle: assert property (@(posedge core_clk_in) disable iff (reset_in)
      rd_in && sel_p2c |=> rdata_out == $past(pll2_control_second_reg)) // RQ10
      else $error("read data wrong");
   a_div_reserved: assert property (@(posedge core_clk_in) disable iff (reset_in)
      pll2_divider_first_reg[3:0] == PLL2_DIVIDER_FIRST_RST[3:0]) // RQ9
      else $error("reserved divide bits changed");
   a_load_range: assert property (@(posedge core_clk_in) disable iff (reset_in)
      osc_b_load_pf_out >= 6'h0A && osc_b_load_pf_out <= 6'h18) // RQ12
      else $error("load out of range");
   a_ratio_flag: assert property (@(posedge core_clk_in) disable iff (reset_in)
      wr_in && sel_p1c |=> setup_p1_out.ratio_select == $past(wdata_in[10])) // RQ8
      else $error("ratio flag not stored");
endmodule // pll_cfg_regs

/* File: testbench/testbench.sv */
// Self-checking bench for the two-PLL configuration register block.
`timescale 1ns/10ps
module testbench;
   import pll_cfg_pkg::*;
   localparam logic [39:0] CFG_MASK = 40'hFF_FF60_07FF;
   logic core_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic [3:0] addr_in = 4'h0;
   logic [39:0] wdata_in = 40'h00_0000_0000;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [39:0] rdata_out, d, v;
   pll_setup_s setup_p1_out, setup_p2_out;
   logic [35:0] divide_value_p2_out;
   logic [2:0] phase_p1_out, phase_p2_out, osc_b_load_code_out, osc_b_drive_gain_out;
   pll_pulse_s pulse_p1_out, pulse_p2_out, q;
   logic osc_b_freq_trim_out;
   logic [5:0] osc_b_load_pf_out;
   logic [31:0] seed = 32'h9C01E803;
   logic [2:0] ph [2];
   int bad_count = 0, n_compared = 0, cycles = 0, n;
   pll_cfg_regs u_pll_cfg_regs (.core_clk_in(core_clk_in), .reset_in(reset_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .setup_p1_out(setup_p1_out), .setup_p2_out(setup_p2_out),
      .divide_value_p2_out(divide_value_p2_out), .phase_p1_out(phase_p1_out),
      .phase_p2_out(phase_p2_out), .pulse_p1_out(pulse_p1_out), .pulse_p2_out(pulse_p2_out),
      .osc_b_freq_trim_out(osc_b_freq_trim_out), .osc_b_load_code_out(osc_b_load_code_out),
      .osc_b_load_pf_out(osc_b_load_pf_out), .osc_b_drive_gain_out(osc_b_drive_gain_out));
   always #20 core_clk_in = ~core_clk_in;
   // ==========================================================
   // Bus tasks and checks
   function automatic logic [31:0] next_rnd(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction
   task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [39:0] dat);
      @(posedge core_clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= dat;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [39:0] val);
      @(posedge core_clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      #1;
      val = rdata_out;
   endtask
   // Writes one control word and follows the step pulses and phase counter.
   task automatic step(input int p, input logic [39:0] dat, input logic ef, input logic eb);
      wr(p ? 4'h9 : 4'h7, dat);
      q = p ? pulse_p2_out : pulse_p1_out;
      chk("phase_fwd", ef, q.phase_fwd);
      chk("phase_back", eb, q.phase_back);
      ph[p] = ph[p] + ef - eb;
      @(posedge core_clk_in);
      #1;
      chk("phase", ph[p], p ? phase_p2_out : phase_p1_out);
   endtask
   task automatic summarize();
      if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Generous ceiling: the whole sequence needs well under two thousand cycles.
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      ph[0] = 3'h0;
      ph[1] = 3'h0;
      repeat (10) @(posedge core_clk_in);
      reset_in <= 1'b0;
      rd(4'h7, v);
      chk("reg7 reset", PLL1_CONTROL_SECOND_RST, v);
      rd(4'h8, v);
      chk("reg8 reset", PLL2_DIVIDER_FIRST_RST, v);
      rd(4'h9, v);
      chk("reg9 reset", PLL2_CONTROL_SECOND_RST, v);
      rd(4'hA, v);
      chk("regA reset", {24'h000000, CRYSTAL_TWO_SETUP_RST}, v);
      for (int i = 0; i < 8; i++) begin
         seed = next_rnd(seed);
         d[39:32] = seed[7:0];
         seed = next_rnd(seed);
         d[31:0] = seed;
         if (i < 2) d[14:12] = i ? 3'h7 : 3'h0;
         for (int p = 0; p < 2; p++) begin
            wr(p ? 4'h9 : 4'h7, d & CFG_MASK);
            rd(p ? 4'h9 : 4'h7, v);
            chk("ctrl readback", d & CFG_MASK, v);
            v = 40'(p ? setup_p2_out : setup_p1_out);
            chk("setup", {d[39:24], d[22:21], d[10:0]}, v);
            wr(p ? 4'h9 : 4'h7, 40'h00_0000_0000);
         end
         wr(4'h8, d);
         rd(4'h8, v);
         chk("divide readback", {d[39:4], 4'hE}, v);
         chk("divide value", d[39:4], divide_value_p2_out);
         wr(4'hA, d);
         rd(4'hA, v);
         chk("osc readback", {24'h000000, d[15:0]}, v);
         chk("osc trim", d[15], osc_b_freq_trim_out);
         chk("osc load code", d[14:12], osc_b_load_code_out);
         chk("osc load pf", 6'(10 + 2 * d[14:12]), osc_b_load_pf_out);
         chk("osc gain", d[11:9], osc_b_drive_gain_out);
      end
      wr(4'h3, 40'hFF_FFFF_FFFF);
      rd(4'h3, v);
      chk("unmapped", 40'h00_0000_0000, v);
      for (int s = 0; s < 4; s++) begin
         for (int p = 0; p < 2; p++) begin
            d = 40'(s) << S_LSB;
            step(p, d | (40'h1 << FWD_BIT), 1'b1, 1'b0);
            step(p, d | (40'h1 << FWD_BIT), 1'b0, 1'b0);
            step(p, d, 1'b0, 1'b0);
            step(p, d | (40'h1 << BACK_BIT), 1'b0, 1'b1);
            step(p, d, 1'b0, 1'b0);
         end
      end
      // Setup change first, then the restart bits, as software is expected to do.
      for (int p = 0; p < 2; p++) begin
         d = 40'h00_A020_0000;
         wr(p ? 4'h9 : 4'h7, d);
         wr(p ? 4'h9 : 4'h7, d | (40'h1 << FB_RESTART_BIT));
         q = p ? pulse_p2_out : pulse_p1_out;
         chk("feedback restart", 1'b1, q.feedback_restart);
         chk("out restart idle", 1'b0, q.out_restart);
         wr(p ? 4'h9 : 4'h7, d | (40'h3 << OUT_RESTART_BIT));
         q = p ? pulse_p2_out : pulse_p1_out;
         chk("feedback restart held", 1'b0, q.feedback_restart);
         chk("out restart", 1'b1, q.out_restart);
         wr(p ? 4'h9 : 4'h7, d);
      end
      step(0, (40'h1 << FWD_BIT) | (40'h1 << BACK_BIT), 1'b1, 1'b1);
      step(0, 40'h00_0000_0000, 1'b0, 1'b0);
      step(0, 40'h1 << FWD_BIT, 1'b1, 1'b0);
      @(posedge core_clk_in);
      reset_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      reset_in <= 1'b0;
      #1;
      ph[0] = 3'h0;
      chk("phase after reset", 3'h0, phase_p1_out);
      rd(4'h7, v);
      chk("reg7 after reset", PLL1_CONTROL_SECOND_RST, v);
      rd(4'h8, v);
      chk("reg8 after reset", PLL2_DIVIDER_FIRST_RST, v);
      for (int p = 0; p < 2; p++) begin
         wr(p ? 4'h9 : 4'h7, 40'h1 << RESYNC_BIT);
         @(posedge core_clk_in);
         #1;
         q = p ? pulse_p2_out : pulse_p1_out;
         chk("resync busy", 1'b1, q.resync_busy);
         for (n = 1; n < 20 && q.resync_sync !== 1'b1; n++) begin
            @(posedge core_clk_in);
            #1;
            q = p ? pulse_p2_out : pulse_p1_out;
         end
         chk("resync sync delay", RESYNC_CYCLES, n);
         @(posedge core_clk_in);
         #1;
         q = p ? pulse_p2_out : pulse_p1_out;
         chk("resync done", 1'b0, q.resync_busy);
         chk("resync sync single", 1'b0, q.resync_sync);
         wr(p ? 4'h9 : 4'h7, 40'h00_0000_0000);
      end
      summarize();
   end
endmodule // testbench
